// file: eeprom_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
module eeprom_serial_port
  import eeprom_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  // Serial pins
  input  wire logic  chip_sel,
  input  wire logic  serial_clk,
  input  wire logic  serial_in_line,
  input  wire logic  word_width_strap,
  output var  logic  serial_out,
  output var  logic  serial_out_oe
);

  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  ser_state_t            state_reg;
  logic                  sclk_prev_reg;
  logic                  cs_prev_reg;
  logic [3:0]            cs_low_cnt_reg;
  logic [1:0]            opcode_reg;
  logic [ADDR_W-1:0]     addr_reg;
  logic [WORD_W-1:0]     shift_reg;
  logic [4:0]            bit_cnt_reg;
  logic                  prog_pending_reg;
  logic                  busy_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic                  status_show_reg;
  logic                  rd_bit_reg;
  logic                  rd_oe_reg;
  logic [MEM_AW-1:0]     mem_addr_reg;
  logic [WORD_W-1:0]     mem_wdata_reg;
  logic [LANES-1:0]      mem_wr_reg;
  logic                  sclk_rise;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  wide;
  logic [4:0]            addr_last;
  logic [4:0]            data_last;
  logic [WORD_W-1:0]     rd_word;
  logic                  cs_low_ok;

  word_port_if mem ();

  word_store u_store (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .port    (mem.store)
  );

  assign sclk_rise = serial_clk & ~sclk_prev_reg;
  assign cs_fall   = ~chip_sel & cs_prev_reg;
  assign cs_rise   = chip_sel & ~cs_prev_reg;
  assign wide      = word_width_strap;
  assign addr_last = wide ? ADDR_BITS_X16 - 5'h01 : ADDR_BITS_X8 - 5'h01;
  assign data_last = wide ? DATA_BITS_X16 - 5'h01 : DATA_BITS_X8 - 5'h01;
  assign cs_low_ok = cs_low_cnt_reg >= CS_LOW_CYCLES;
  // Eight-bit words sit left-aligned so that the shift path is shared.
  assign rd_word   = wide ? mem.rdata : (addr_reg[0] ? {mem.rdata[15:8], 8'h00} : {mem.rdata[7:0], 8'h00});

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b0;
    end else if (clk_en) begin
      sclk_prev_reg <= serial_clk;
      cs_prev_reg   <= chip_sel;
    end
  end

  // Counts the deselect time; it is read on the rising edge of select.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_low_cnt_reg <= 4'h0;
    end else if (clk_en) begin
      if (chip_sel) begin
        cs_low_cnt_reg <= 4'h0;
      end else if (!cs_low_ok) begin
        cs_low_cnt_reg <= cs_low_cnt_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= ST_IDLE;
      opcode_reg  <= 2'h0;
      addr_reg    <= '0;
      shift_reg   <= WORD_RESET;
      bit_cnt_reg <= 5'h00;
      rd_bit_reg  <= 1'b0;
      rd_oe_reg   <= 1'b0;
    end else if (clk_en) begin
      if (!chip_sel) begin
        state_reg <= ST_IDLE;
        rd_oe_reg <= 1'b0;
      end else if (sclk_rise) begin
        unique case (state_reg)
          ST_IDLE: begin
            // A new instruction waits until programming has finished.
            if (serial_in_line && !busy_reg) begin
              state_reg   <= ST_OPCODE;
              bit_cnt_reg <= 5'h00;
            end
          end
          ST_OPCODE: begin
            opcode_reg  <= {opcode_reg[0], serial_in_line};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == OPCODE_LAST) begin
              state_reg   <= ST_ADDR;
              bit_cnt_reg <= 5'h00;
            end
          end
          ST_ADDR: begin
            addr_reg    <= wide ? {1'b0, addr_reg[4:0], serial_in_line} : {addr_reg[5:0], serial_in_line};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == addr_last) begin
              bit_cnt_reg <= 5'h00;
              if (opcode_reg == OP_READ) begin
                state_reg  <= ST_READ;
                rd_bit_reg <= 1'b0;
                rd_oe_reg  <= 1'b1;
              end else if (opcode_reg == OP_WRITE) begin
                state_reg <= ST_DATA;
              end else begin
                state_reg <= ST_DONE;
              end
            end
          end
          ST_DATA: begin
            shift_reg   <= {shift_reg[14:0], serial_in_line};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == data_last) begin
              state_reg <= ST_DONE;
            end
          end
          ST_READ: begin
            if (bit_cnt_reg == 5'h00) begin
              rd_bit_reg <= rd_word[15];
              shift_reg  <= {rd_word[14:0], 1'b0};
            end else begin
              rd_bit_reg <= shift_reg[15];
              shift_reg  <= {shift_reg[14:0], 1'b0};
            end
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            // Select held high rolls on to the next word.
            if (bit_cnt_reg == data_last) begin
              bit_cnt_reg <= 5'h00;
              addr_reg    <= wide ? {1'b0, addr_reg[5:0] + 6'h01} : addr_reg + 7'h01;
            end
          end
          ST_DONE: begin
            state_reg <= ST_DONE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Programming launch and busy timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        prog_pending_reg <= 1'b0;
      end else if (chip_sel && sclk_rise && state_reg == ST_ADDR && bit_cnt_reg == addr_last) begin
        prog_pending_reg <= opcode_reg == OP_ERASE;
      end else if (chip_sel && sclk_rise && state_reg == ST_DATA && bit_cnt_reg == data_last) begin
        prog_pending_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (clk_en) begin
      if (cs_fall && prog_pending_reg) begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= BUSY_CNT_W'(PROG_CYCLES_P - 1);
      end else if (busy_reg) begin
        if (busy_cnt_reg == '0) begin
          busy_reg <= 1'b0;
        end else begin
          busy_cnt_reg <= busy_cnt_reg - BUSY_CNT_W'(1);
        end
      end
    end
  end

  // The array is written at launch; the busy time only models the self-timed cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_wr_reg    <= '0;
      mem_wdata_reg <= WORD_RESET;
      mem_addr_reg  <= '0;
    end else if (clk_en) begin
      mem_wr_reg   <= '0;
      mem_addr_reg <= wide ? addr_reg[5:0] : addr_reg[6:1];
      if (cs_fall && prog_pending_reg) begin
        mem_wr_reg    <= wide ? 2'h3 : (addr_reg[0] ? 2'h2 : 2'h1);
        mem_wdata_reg <= opcode_reg == OP_ERASE ? ERASED_WORD :
                         (wide ? shift_reg : {shift_reg[7:0], shift_reg[7:0]});
      end
    end
  end

  assign mem.addr  = mem_addr_reg;
  assign mem.wdata = mem_wdata_reg;
  assign mem.wr_en = mem_wr_reg;

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_show_reg <= 1'b0;
    end else if (clk_en) begin
      if (!chip_sel) begin
        status_show_reg <= 1'b0;
      end else if (cs_rise && cs_low_ok && busy_reg) begin
        status_show_reg <= 1'b1;
      end else if (sclk_rise && state_reg == ST_IDLE && serial_in_line && !busy_reg) begin
        status_show_reg <= 1'b0;
      end
    end
  end

  // One more register stage keeps the pin straight off a flip-flop.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      serial_out    <= status_show_reg ? ~busy_reg : rd_bit_reg;
      serial_out_oe <= chip_sel & (status_show_reg | rd_oe_reg);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  hiz_deselect_a: assert property ((clk_en && !chip_sel) |=> !serial_out_oe)
    else $error("output driven while deselected");
  ctrl_reset_a: assert property ((clk_en && !chip_sel) |=> state_reg == ST_IDLE)
    else $error("sequencer not held idle while deselected");
  status_level_a: assert property ((clk_en && chip_sel && status_show_reg) |=>
      serial_out_oe && serial_out == !$past(busy_reg))
    else $error("status level wrong");
  status_gate_a: assert property ($rose(status_show_reg) |->
      $past(cs_low_cnt_reg) >= CS_LOW_CYCLES && $past(busy_reg) && $past(cs_rise))
    else $error("status shown without qualified select rise");
  status_low_a: assert property ((clk_en && !chip_sel) |=> !status_show_reg)
    else $error("status kept while select low");
  busy_end_a: assert property ($fell(busy_reg) |-> $past(busy_cnt_reg) == '0)
    else $error("busy ended before count expired");
  dummy_zero_a: assert property ($rose(state_reg == ST_READ) |-> rd_oe_reg && !rd_bit_reg)
    else $error("read did not open with a zero");
  data_width_a: assert property ($fell(state_reg == ST_DATA) && chip_sel |->
      $past(bit_cnt_reg) == (word_width_strap ? 5'h0F : 5'h07))
    else $error("write data length does not follow the strap");
  edge_step_a: assert property ((chip_sel && $past(chip_sel) && state_reg != $past(state_reg)) |->
      $past(sclk_rise && clk_en))
    else $error("sequencer moved without a serial clock edge");
  read_bit_a: assert property ((clk_en && chip_sel && sclk_rise && state_reg == ST_READ && bit_cnt_reg != 5'h00
      && !status_show_reg) ##1 (clk_en && chip_sel && !status_show_reg) |=> serial_out == $past(shift_reg[15], 2))
    else $error("read bit not shifted out");

  read_seen_c: cover property ($rose(state_reg == ST_READ));
  status_busy_c: cover property (status_show_reg && busy_reg ##1 status_show_reg && !busy_reg);
  launch_c: cover property ($rose(busy_reg));

endmodule : eeprom_serial_port
`default_nettype wire

// file: eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          CS_LOW_MIN_NS   = 250;
  // A least time rounds up to whole clock cycles.
  localparam logic [3:0]  CS_LOW_CYCLES   = 4'((CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          PROG_TIME_US    = 4;
  localparam int          PROG_CYCLES     = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int          BUSY_CNT_W      = 18;

  // ----------------------------------------------------------------
  // Word store and frame layout
  // ----------------------------------------------------------------
  localparam int          WORD_W          = 16;
  localparam int          LANE_W          = 8;
  localparam int          LANES           = 2;
  localparam int          MEM_AW          = 6;
  localparam int          MEM_DEPTH       = 64;
  localparam int          ADDR_W          = 7;
  localparam logic [4:0]  OPCODE_LAST     = 5'h01;
  localparam logic [4:0]  ADDR_BITS_X16   = 5'h06;
  localparam logic [4:0]  ADDR_BITS_X8    = 5'h07;
  localparam logic [4:0]  DATA_BITS_X16   = 5'h10;
  localparam logic [4:0]  DATA_BITS_X8    = 5'h08;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF;
  localparam logic [15:0] WORD_RESET      = 16'h0000;

  // ----------------------------------------------------------------
  // Opcodes and states
  // ----------------------------------------------------------------
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_ERASE        = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPCODE = 3'h1,
    ST_ADDR   = 3'h2,
    ST_DATA   = 3'h3,
    ST_READ   = 3'h4,
    ST_DONE   = 3'h5
  } ser_state_t;

endpackage : eeprom_pkg
`default_nettype wire

// file: word_port_if.sv
`timescale 1ns/10ps
`default_nettype none
interface word_port_if;
  import eeprom_pkg::*;
  logic [MEM_AW-1:0] addr;
  logic [WORD_W-1:0] wdata;
  logic [LANES-1:0]  wr_en;
  logic [WORD_W-1:0] rdata;
  modport ctrl  (output addr, output wdata, output wr_en, input rdata);
  modport store (input addr, input wdata, input wr_en, output rdata);
endinterface : word_port_if
`default_nettype wire

// file: word_store.sv
`timescale 1ns/10ps
`default_nettype none
module word_store
  import eeprom_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   reset_n,
  input  wire logic   clk_en,
  // Word port
  word_port_if.store  port
);

  logic [WORD_W-1:0] rdata_reg;
  logic [WORD_W-1:0] rdata_next;

  // Each byte lane is an array of its own, so a narrow write leaves the other lane alone.
  for (genvar lane = 0; lane < LANES; lane++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [MEM_DEPTH];

    always_ff @(posedge ref_clk) begin
      if (clk_en && port.wr_en[lane]) begin
        lane_mem[port.addr] <= port.wdata[lane*LANE_W +: LANE_W];
      end
    end

    assign rdata_next[lane*LANE_W +: LANE_W] = lane_mem[port.addr];
  end

  // Read data always comes out of a register, one cycle after the address.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= WORD_RESET;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign port.rdata = rdata_reg;

endmodule : word_store
`default_nettype wire

// file: host_serial_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
  // Reference clock
  input  wire logic ref_clk,
  // Serial pins toward the device
  output var  logic chip_sel,
  output var  logic serial_clk,
  output var  logic serial_in_line,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  // ----------------------------------------------------------------
  // Pacing
  // ----------------------------------------------------------------
  // Four reference cycles low and five high put the serial clock well above 1 MHz, so the strap is never floated.
  localparam int HALF_CYCLES     = 4;
  localparam int DESELECT_CYCLES = 14;

  logic last_out;
  logic last_oe;

  initial begin
    chip_sel       <= 1'b0;
    serial_clk     <= 1'b0;
    serial_in_line <= 1'b0;
    last_out       = 1'b0;
    last_oe        = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus actions
  // ----------------------------------------------------------------
  // The input line is of no interest while deselected, so it wanders to catch any use of it.
  task automatic deselect();
    @(posedge ref_clk);
    chip_sel   <= 1'b0;
    serial_clk <= 1'b0;
    for (int i = 0; i < DESELECT_CYCLES; i++) begin
      @(posedge ref_clk);
      serial_in_line <= ~serial_in_line;
    end
  endtask : deselect

  task automatic select();
    @(posedge ref_clk);
    chip_sel <= 1'b1;
  endtask : select

  // A deliberately short low time, used to show that status needs the full minimum.
  task automatic pulse_low(input int n);
    @(posedge ref_clk);
    chip_sel   <= 1'b0;
    serial_clk <= 1'b0;
    repeat (n) @(posedge ref_clk);
    chip_sel <= 1'b1;
  endtask : pulse_low

  // Data changes while the serial clock is low and the answer is taken just before it falls.
  task automatic clock_bit(input logic b);
    @(posedge ref_clk);
    serial_in_line <= b;
    repeat (HALF_CYCLES - 1) @(posedge ref_clk);
    serial_clk <= 1'b1;
    repeat (HALF_CYCLES) @(posedge ref_clk);
    @(negedge ref_clk);
    // A released line floats up to its pull-up level.
    last_out = serial_out_oe ? serial_out : 1'b1;
    last_oe  = serial_out_oe;
    @(posedge ref_clk);
    serial_clk <= 1'b0;
  endtask : clock_bit

  task automatic send(input logic [31:0] value, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      clock_bit(value[i]);
    end
  endtask : send

  task automatic receive(input int n, output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < n; i++) begin
      clock_bit(1'b0);
      w = {w[14:0], last_out};
    end
  endtask : receive
endmodule : host_serial_model
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import eeprom_pkg::*;

  localparam int unsigned PROG_TEST = 100;

  logic ref_clk;
  logic reset_n;
  logic clk_en;
  logic word_width_strap;
  logic chip_sel;
  logic serial_clk;
  logic serial_in_line;
  logic serial_out;
  logic serial_out_oe;
  int   errors;
  int   samples_checked;

  eeprom_serial_port #(.PROG_CYCLES_P(PROG_TEST)) eeprom_serial_port_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .chip_sel(chip_sel),
    .serial_clk(serial_clk), .serial_in_line(serial_in_line), .word_width_strap(word_width_strap),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  host_serial_model host_serial_model_inst (
    .ref_clk(ref_clk), .chip_sel(chip_sel), .serial_clk(serial_clk), .serial_in_line(serial_in_line),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check

  task automatic test_done();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // The serial clock runs above 1 MHz, so the strap is always driven to a level.
  task automatic set_strap(input logic v);
    @(posedge ref_clk);
    word_width_strap <= v;
  endtask : set_strap

  // The opcode selects erase; an erase sends no data bits after the address.
  task automatic program_op(input logic [1:0] op, input logic [6:0] addr, input int an,
                            input logic [15:0] data, input int dn);
    host_serial_model_inst.deselect();
    host_serial_model_inst.select();
    host_serial_model_inst.send({29'h0, 1'b1, op}, 3);
    host_serial_model_inst.send(32'(addr), an);
    host_serial_model_inst.send(32'(data), dn);
  endtask : program_op

  task automatic read_check(input logic [6:0] addr, input int an, input int dn, input logic [15:0] expected);
    logic [15:0] w;
    host_serial_model_inst.deselect();
    host_serial_model_inst.select();
    host_serial_model_inst.send({29'h0, 1'b1, OP_READ}, 3);
    check(16'(host_serial_model_inst.last_oe), 16'h0000);
    host_serial_model_inst.send(32'(addr), an);
    check({14'h0, host_serial_model_inst.last_oe, host_serial_model_inst.last_out}, 16'h0002);
    host_serial_model_inst.receive(dn, w);
    check(w, expected);
  endtask : read_check

  // The launching fall is the deselect at the start, or in test_short_low the short low before it, so the raise lands well inside the busy time.
  task automatic show_status();
    int n;
    host_serial_model_inst.deselect();
    host_serial_model_inst.select();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(16'(serial_out_oe), 16'h0001);
    check(16'(serial_out), 16'h0000);
    n = 0;
    while (serial_out !== 1'b1 && n < 2 * PROG_TEST) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0, serial_out & serial_out_oe}, 16'h0001);
    host_serial_model_inst.deselect();
    @(negedge ref_clk);
    check(16'(serial_out_oe), 16'h0000);
  endtask : show_status

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_wide_word();
    set_strap(1'b1);
    program_op(OP_WRITE, 7'h2A, 6, 16'hC35A, 16);
    show_status();
    read_check(7'h2A, 6, 16, 16'hC35A);
  endtask : test_wide_word

  // The upper byte of word 2A is the odd byte address, so erasing it shows through a wide read.
  task automatic test_byte_lane();
    set_strap(1'b0);
    program_op(OP_WRITE, 7'h55, 7, 16'h0096, 8);
    show_status();
    read_check(7'h55, 7, 8, 16'h0096);
    program_op(OP_ERASE, 7'h55, 7, 16'h0000, 0);
    show_status();
    read_check(7'h55, 7, 8, 16'h00FF);
    set_strap(1'b1);
    read_check(7'h2A, 6, 16, 16'hFF5A);
  endtask : test_byte_lane

  task automatic test_no_status();
    int hits;
    hits = 0;
    program_op(OP_WRITE, 7'h01, 6, 16'h1234, 16);
    host_serial_model_inst.deselect();
    for (int i = 0; i < 2 * PROG_TEST; i++) begin
      @(negedge ref_clk);
      if (serial_out_oe !== 1'b0) hits++;
    end
    check(16'(hits), 16'h0000);
    host_serial_model_inst.select();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(16'(serial_out_oe), 16'h0000);
    read_check(7'h01, 6, 16, 16'h1234);
  endtask : test_no_status

  task automatic test_abort();
    host_serial_model_inst.deselect();
    host_serial_model_inst.select();
    host_serial_model_inst.send({29'h0, 1'b1, OP_READ}, 3);
    host_serial_model_inst.send(32'h5, 3);
    host_serial_model_inst.deselect();
    @(negedge ref_clk);
    check(16'(serial_out_oe), 16'h0000);
    read_check(7'h2A, 6, 16, 16'hFF5A);
  endtask : test_abort

  // A raise after too short a low time must not open the status window.
  task automatic test_short_low();
    program_op(OP_ERASE, 7'h03, 6, 16'h0000, 0);
    host_serial_model_inst.pulse_low(4);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(16'(serial_out_oe), 16'h0000);
    show_status();
    read_check(7'h03, 6, 16, 16'hFFFF);
  endtask : test_short_low

  // A frozen block must not count down its busy time.
  task automatic test_freeze();
    int n;
    program_op(OP_WRITE, 7'h02, 6, 16'h0F0F, 16);
    host_serial_model_inst.deselect();
    host_serial_model_inst.select();
    repeat (3) @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (2 * PROG_TEST) @(posedge ref_clk);
    @(negedge ref_clk);
    check({14'h0, serial_out_oe, serial_out}, 16'h0002);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    n = 0;
    while (serial_out !== 1'b1 && n < 2 * PROG_TEST) begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(n > PROG_TEST / 2), 16'h0001);
    check({15'h0, serial_out & serial_out_oe}, 16'h0001);
    read_check(7'h02, 6, 16, 16'h0F0F);
  endtask : test_freeze

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk          = 1'b0;
    reset_n          <= 1'b0;
    clk_en           <= 1'b1;
    word_width_strap <= 1'b1;
    errors           = 0;
    samples_checked  = 0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    check({14'h0, serial_out_oe, serial_out}, 16'h0000);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    test_wide_word();
    test_byte_lane();
    test_no_status();
    test_abort();
    test_short_low();
    test_freeze();
    test_done();
  end

  // The whole run needs well under ten thousand cycles.
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire
